// file: core/privilege_mode_pkg.sv
/*
  Shared types and constants for the operating-mode decode block:
  register offsets, field positions, reset values, mode and space enums.
  Assumes a single 125 MHz core clock and an AXI4-Lite register bus.
*/
package privilege_mode_pkg;

  // ----------------------------------------------------------------
  // Register map and bus constants
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEBUG_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FP_ID = 8'h08;
  localparam logic [7:0] ADDR_MODE_VIEW = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_EXL = 0;
  localparam int unsigned ST_ERL = 1;
  localparam int unsigned ST_PRIV_LSB = 2;
  localparam int unsigned ST_KX = 4;
  localparam int unsigned ST_SX = 5;
  localparam int unsigned ST_UX = 6;
  localparam int unsigned ST_PX = 7;
  localparam int unsigned ST_FR = 8;
  localparam int unsigned ST_CU0 = 9;
  localparam int unsigned DBG_ACTIVE = 0;
  localparam int unsigned FPID_WIDE = 0;
  localparam int unsigned FPID_DTYPE = 1;
  localparam int unsigned MV_MODE_LSB = 0;
  localparam int unsigned MV_WIDE_INT = 2;
  localparam int unsigned MV_FP_WIDE = 3;
  localparam int unsigned MV_FP_REG64 = 4;
  localparam int unsigned MV_SYS_COP = 5;
  localparam int unsigned MV_KADDR = 6;
  localparam int unsigned MV_SADDR = 7;
  localparam int unsigned MV_UADDR = 8;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_SUPER = 2'h1;
  localparam logic [1:0] PRIV_USER = 2'h2;
  localparam int unsigned NUM_COPROC = 4;
  localparam int unsigned NUM_FLOAT_REGS = 32;

  typedef enum logic [1:0] {MODE_KERNEL, MODE_SUPER, MODE_USER, MODE_DEBUG} mode_t;
  typedef enum logic [1:0] {SPACE_KERNEL, SPACE_SUPER, SPACE_USER} space_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic debug_active_bit;
    logic [1:0] privilege_level_field;
    logic exception_level_bit;
    logic error_level_bit;
    logic kernel_wide_addr_enable;
    logic super_wide_addr_enable;
    logic user_wide_addr_enable;
    logic wide_op_enable;
    logic fp_reg_width_bit;
    logic sys_coproc_usable;
  } mode_bits_t;

  typedef struct packed {
    mode_t mode;
    logic wide_int_en;
    logic fp_wide_en;
    logic fp_reg_64;
    logic sys_coproc_en;
    logic kernel_addr_en;
    logic super_addr_en;
    logic user_addr_en;
  } enables_t;

  typedef struct packed {
    logic ref_valid;
    space_t space;
    logic is_wide;
    logic is_store;
    logic tlb_miss;
    logic wide_int_op;
    logic fp_wide_op;
    logic cop_op;
    logic [1:0] cop_num;
  } ref_req_t;

  typedef struct packed {
    logic addr_error_load;
    logic addr_error_store;
    logic refill_compat;
    logic extended_refill;
    logic reserved_instr;
    logic cop_unusable;
  } fault_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axil_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_s2m_t;

  localparam mode_bits_t BITS_RESET = '{
    debug_active_bit: 1'b0, privilege_level_field: PRIV_KERNEL,
    exception_level_bit: 1'b0, error_level_bit: 1'b1,
    kernel_wide_addr_enable: 1'b0, super_wide_addr_enable: 1'b0,
    user_wide_addr_enable: 1'b0, wide_op_enable: 1'b0,
    fp_reg_width_bit: 1'b0, sys_coproc_usable: 1'b0};

  localparam enables_t EN_RESET = '{
    mode: MODE_KERNEL, wide_int_en: 1'b1, fp_wide_en: 1'b0, fp_reg_64: 1'b0,
    sys_coproc_en: 1'b1, kernel_addr_en: 1'b0, super_addr_en: 1'b0,
    user_addr_en: 1'b0};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic kernel_like(input mode_t m);
    kernel_like = (m == MODE_KERNEL) || (m == MODE_DEBUG);
  endfunction : kernel_like

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      strb_merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : strb_merge

endpackage : privilege_mode_pkg

// file: core/mode_decode.sv
/*
  Combinational decode of the operating mode and the derived enables.
  Assumes its inputs come from flip-flops on the core clock.
*/
`timescale 1ns/1ps
module mode_decode
  import privilege_mode_pkg::*;
#(
  parameter bit DEBUG_IMPL = 1'b1,
  parameter bit SUPER_IMPL = 1'b1,
  parameter bit RELEASE_TWO = 1'b1
)(
  input wire mode_bits_t bits_i, // Current control bits
  input wire logic fp_wide_capable_i, // Float unit is 64-bit capable
  input wire logic fp_datatype_i, // Float data type implemented
  output enables_t en_o // Decoded mode and enables
);

  always_comb
  begin
    en_o = EN_RESET;
    if (DEBUG_IMPL && bits_i.debug_active_bit)
    begin
      en_o.mode = MODE_DEBUG;
    end
    else if (bits_i.privilege_level_field == PRIV_KERNEL ||
             bits_i.exception_level_bit || bits_i.error_level_bit)
    begin
      en_o.mode = MODE_KERNEL;
    end
    else if (SUPER_IMPL && bits_i.privilege_level_field == PRIV_SUPER)
    begin
      en_o.mode = MODE_SUPER;
    end
    // user; unused codes fall here too, the least privileged choice
    else
    begin
      en_o.mode = MODE_USER;
    end
    en_o.wide_int_en = kernel_like(en_o.mode) || en_o.mode == MODE_SUPER ||
                       bits_i.wide_op_enable ||
                       (en_o.mode == MODE_USER && bits_i.user_wide_addr_enable);
    en_o.fp_wide_en = RELEASE_TWO ? (fp_wide_capable_i && fp_datatype_i)
                                  : en_o.wide_int_en;
    en_o.fp_reg_64 = bits_i.fp_reg_width_bit;
    en_o.sys_coproc_en = kernel_like(en_o.mode) || bits_i.sys_coproc_usable;
    en_o.kernel_addr_en = bits_i.kernel_wide_addr_enable;
    en_o.super_addr_en = bits_i.super_wide_addr_enable;
    en_o.user_addr_en = bits_i.user_wide_addr_enable;
  end

endmodule : mode_decode

// file: core/fault_select.sv
/*
  Combinational selection of address error, refill vector, reserved
  instruction and coprocessor unusable outcomes for one reference.
  Assumes the caller classifies the reference's space and width.
*/
`timescale 1ns/1ps
module fault_select
  import privilege_mode_pkg::*;
#(
  parameter logic [NUM_COPROC-1:0] COPROC_PRESENT = 4'h3
)(
  input wire enables_t en_i, // Registered enables
  input wire ref_req_t req_i, // Reference being checked
  output fault_t fault_o // Selected outcomes
);

  logic space_en;

  always_comb
  begin
    fault_o = '0;
    // enable taken from the target space
    unique case (req_i.space)
      SPACE_KERNEL: space_en = en_i.kernel_addr_en;
      SPACE_SUPER: space_en = en_i.super_addr_en;
      default: space_en = en_i.user_addr_en;
    endcase
    if (req_i.ref_valid)
    begin
      // load code for loads and fetches
      fault_o.addr_error_load = req_i.is_wide && !space_en && !req_i.is_store;
      fault_o.addr_error_store = req_i.is_wide && !space_en && req_i.is_store;
      // vector choice; an address error takes precedence
      if (req_i.tlb_miss && !(req_i.is_wide && !space_en))
      begin
        fault_o.extended_refill = space_en;
        fault_o.refill_compat = !space_en;
      end
    end
    fault_o.reserved_instr = (req_i.wide_int_op && !en_i.wide_int_en) ||
                             (req_i.fp_wide_op && !en_i.fp_wide_en);
    // absent units and guarded system unit
    fault_o.cop_unusable = req_i.cop_op && (!COPROC_PRESENT[req_i.cop_num] ||
                           (req_i.cop_num == 2'h0 && !en_i.sys_coproc_en));
  end

endmodule : fault_select

// file: core/privilege_mode_decode.sv
/*
  Operating-mode decode for the system coprocessor: holds the mode
  control bits, takes mode events from the core, derives the enables and
  selects exception outcomes. Registers sit behind an AXI4-Lite slave.
  Assumes all event inputs come from logic on the same clock.
*/
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.

`timescale 1ns/1ps
module privilege_mode_decode
  import privilege_mode_pkg::*;
#(
  parameter bit DEBUG_IMPL = 1'b1,
  parameter bit SUPER_IMPL = 1'b1,
  parameter bit RELEASE_TWO = 1'b1,
  parameter bit FP_WIDE_CAPABLE = 1'b1,
  parameter bit FP_DATATYPE = 1'b1,
  parameter logic [NUM_COPROC-1:0] COPROC_PRESENT = 4'h3
)(
  input wire logic clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire axil_m2s_t axil_i, // Register bus, master side
  output axil_s2m_t axil_o, // Register bus, slave side
  input wire logic exc_entry_i, // Exception or interrupt taken
  input wire logic err_entry_i, // Error condition taken
  input wire logic exception_return_i, // Return from exception
  input wire logic debug_entry_i, // Debug entry
  input wire logic debug_return_i, // Debug return
  input wire ref_req_t req_i, // Reference and op to check
  output enables_t en_o, // Registered mode and enables
  output fault_t fault_o // Outcome for req_i
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_bits_t bits;
    enables_t en;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RESET = '{
    bits: BITS_RESET, en: EN_RESET, aw_held: 1'b0, aw_addr: '0,
    w_held: 1'b0, w_data: '0, w_strb: '0, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY};

  state_t s_r;
  state_t s_nxt;
  enables_t en_dec;
  logic [31:0] status_img;
  logic [31:0] debug_img;
  logic [31:0] fpid_img;
  logic [31:0] view_img;

  // ----------------------------------------------------------------
  // Decode of the current bits
  // ----------------------------------------------------------------
  mode_decode #(
    .DEBUG_IMPL(DEBUG_IMPL),
    .SUPER_IMPL(SUPER_IMPL),
    .RELEASE_TWO(RELEASE_TWO)
  ) u_mode_decode (
    .bits_i(s_r.bits),
    .fp_wide_capable_i(FP_WIDE_CAPABLE),
    .fp_datatype_i(FP_DATATYPE),
    .en_o(en_dec)
  );

  fault_select #(
    .COPROC_PRESENT(COPROC_PRESENT)
  ) u_fault_select (
    .en_i(s_r.en),
    .req_i(req_i),
    .fault_o(fault_o)
  );

  assign en_o = s_r.en;

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb
  begin
    status_img = '0;
    status_img[ST_EXL] = s_r.bits.exception_level_bit;
    status_img[ST_ERL] = s_r.bits.error_level_bit;
    status_img[ST_PRIV_LSB +: 2] = s_r.bits.privilege_level_field;
    status_img[ST_KX] = s_r.bits.kernel_wide_addr_enable;
    status_img[ST_SX] = s_r.bits.super_wide_addr_enable;
    status_img[ST_UX] = s_r.bits.user_wide_addr_enable;
    status_img[ST_PX] = s_r.bits.wide_op_enable;
    status_img[ST_FR] = s_r.bits.fp_reg_width_bit;
    status_img[ST_CU0] = s_r.bits.sys_coproc_usable;
    debug_img = '0;
    debug_img[DBG_ACTIVE] = s_r.bits.debug_active_bit;
    fpid_img = '0;
    fpid_img[FPID_WIDE] = FP_WIDE_CAPABLE;
    fpid_img[FPID_DTYPE] = FP_DATATYPE;
    view_img = '0;
    view_img[MV_MODE_LSB +: 2] = s_r.en.mode;
    view_img[MV_WIDE_INT] = s_r.en.wide_int_en;
    view_img[MV_FP_WIDE] = s_r.en.fp_wide_en;
    view_img[MV_FP_REG64] = s_r.en.fp_reg_64;
    view_img[MV_SYS_COP] = s_r.en.sys_coproc_en;
    view_img[MV_KADDR] = s_r.en.kernel_addr_en;
    view_img[MV_SADDR] = s_r.en.super_addr_en;
    view_img[MV_UADDR] = s_r.en.user_addr_en;
  end

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // A held half blocks its own write channel, and a pending response blocks both, until the response is taken
  always_comb
  begin
    axil_o.awready = !s_r.aw_held && !s_r.bvalid;
    axil_o.wready = !s_r.w_held && !s_r.bvalid;
    axil_o.bvalid = s_r.bvalid;
    axil_o.bresp = s_r.bresp;
    axil_o.arready = !s_r.rvalid;
    axil_o.rvalid = s_r.rvalid;
    axil_o.rdata = s_r.rdata;
    axil_o.rresp = s_r.rresp;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] wimg;
    wimg = '0;
    s_nxt = s_r;

    // enables follow the bits one cycle later
    s_nxt.en = en_dec;

    if (axil_i.awvalid && axil_o.awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = axil_i.awaddr;
    end
    if (axil_i.wvalid && axil_o.wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = axil_i.wdata;
      s_nxt.w_strb = axil_i.wstrb;
    end
    if (s_r.bvalid && axil_i.bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // Software write once both halves are in
    if (s_nxt.aw_held && s_nxt.w_held)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_nxt.aw_addr)
        ADDR_STATUS_CTRL:
        begin
          wimg = strb_merge(status_img, s_nxt.w_data, s_nxt.w_strb);
          s_nxt.bits.exception_level_bit = wimg[ST_EXL];
          s_nxt.bits.error_level_bit = wimg[ST_ERL];
          s_nxt.bits.privilege_level_field = wimg[ST_PRIV_LSB +: 2];
          s_nxt.bits.kernel_wide_addr_enable = wimg[ST_KX];
          s_nxt.bits.super_wide_addr_enable = wimg[ST_SX];
          s_nxt.bits.user_wide_addr_enable = wimg[ST_UX];
          s_nxt.bits.wide_op_enable = wimg[ST_PX];
          s_nxt.bits.fp_reg_width_bit = wimg[ST_FR];
          s_nxt.bits.sys_coproc_usable = wimg[ST_CU0];
        end
        ADDR_DEBUG_CTRL:
        begin
          wimg = strb_merge(debug_img, s_nxt.w_data, s_nxt.w_strb);
          s_nxt.bits.debug_active_bit = wimg[DBG_ACTIVE] && DEBUG_IMPL;
        end
        // Identification and view registers are read only
        ADDR_FP_ID, ADDR_MODE_VIEW:
        begin
          s_nxt.bresp = RESP_OKAY;
        end
        default:
        begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // return drops error level first, else exception level
    if (exception_return_i)
    begin
      if (s_r.bits.error_level_bit)
      begin
        s_nxt.bits.error_level_bit = 1'b0;
      end
      else
      begin
        s_nxt.bits.exception_level_bit = 1'b0;
      end
    end
    if (debug_return_i)
    begin
      s_nxt.bits.debug_active_bit = 1'b0;
    end

    // entry events win over any clear in the same cycle
    if (exc_entry_i)
    begin
      s_nxt.bits.exception_level_bit = 1'b1;
    end
    if (err_entry_i)
    begin
      s_nxt.bits.error_level_bit = 1'b1;
    end
    // debug bit only exists where debug is built
    if (debug_entry_i && DEBUG_IMPL)
    begin
      s_nxt.bits.debug_active_bit = 1'b1;
    end

    // Reads see state from before this edge
    if (s_r.rvalid && axil_i.rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (axil_i.arvalid && axil_o.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      unique case (axil_i.araddr)
        ADDR_STATUS_CTRL: s_nxt.rdata = status_img;
        ADDR_DEBUG_CTRL: s_nxt.rdata = debug_img;
        ADDR_FP_ID: s_nxt.rdata = fpid_img;
        ADDR_MODE_VIEW: s_nxt.rdata = view_img;
        default:
        begin
          s_nxt.rdata = '0;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // reset lands in kernel through the error level bit
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_r <= STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : privilege_mode_decode

// file: verification/privilege_mode_decode_sva.sv
/*
  Port assertions for the operating-mode decode block.
  Assumes one core clock and the async active-low reset; bound below.
*/
`timescale 1ns/1ps
module privilege_mode_decode_sva
  import privilege_mode_pkg::*;
#(
  parameter bit RELEASE_TWO = 1'b1,
  parameter bit FP_WIDE_CAPABLE = 1'b1,
  parameter bit FP_DATATYPE = 1'b1,
  parameter logic [NUM_COPROC-1:0] COPROC_PRESENT = 4'h3
)(
  input wire logic clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire axil_s2m_t axil_o, // Bus slave side
  input wire logic exc_entry_i, // Exception taken
  input wire logic err_entry_i, // Error taken
  input wire logic debug_entry_i, // Debug entry
  input wire ref_req_t req_i, // Reference checked
  input wire enables_t en_o, // Mode and enables
  input wire fault_t fault_o // Selected outcomes
);
  logic sp_en;
  logic adr_err;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Enable of the target space, never of the mode
  always_comb
  begin
    case (req_i.space)
      SPACE_KERNEL: sp_en = en_o.kernel_addr_en;
      SPACE_SUPER: sp_en = en_o.super_addr_en;
      default: sp_en = en_o.user_addr_en;
    endcase
  end
  assign adr_err = req_i.ref_valid && req_i.is_wide && !sp_en;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_dbg_entry;
    debug_entry_i |-> ##2 en_o.mode == MODE_DEBUG;
  endproperty
  property p_dbg_priv;
    en_o.mode == MODE_DEBUG |-> en_o.wide_int_en && en_o.sys_coproc_en;
  endproperty
  property p_entry_kernel;
    exc_entry_i || err_entry_i |-> ##2 (en_o.mode == MODE_KERNEL || en_o.mode == MODE_DEBUG);
  endproperty
  property p_kernel_priv;
    en_o.mode == MODE_KERNEL |-> en_o.wide_int_en && en_o.sys_coproc_en;
  endproperty
  property p_user_op;
    en_o.mode == MODE_USER && en_o.user_addr_en |-> en_o.wide_int_en;
  endproperty
  property p_addr_err;
    req_i.ref_valid && req_i.is_wide |->
      fault_o.addr_error_load == (adr_err && !req_i.is_store) &&
      fault_o.addr_error_store == (adr_err && req_i.is_store);
  endproperty
  property p_refill;
    req_i.ref_valid && req_i.tlb_miss && !adr_err |->
      fault_o.extended_refill == sp_en && fault_o.refill_compat == !sp_en;
  endproperty
  property p_resv;
    fault_o.reserved_instr == ((req_i.wide_int_op && !en_o.wide_int_en) ||
                               (req_i.fp_wide_op && !en_o.fp_wide_en));
  endproperty
  property p_sys_cop;
    req_i.cop_op && req_i.cop_num == 2'h0 |->
      fault_o.cop_unusable == !en_o.sys_coproc_en;
  endproperty
  property p_cop_absent;
    req_i.cop_op && req_i.cop_num != 2'h0 |->
      fault_o.cop_unusable == !COPROC_PRESENT[req_i.cop_num];
  endproperty
  // First edge after release still shows the reset enables
  property p_fp_wide;
    $past(arst_n_i) |-> en_o.fp_wide_en ==
      (RELEASE_TWO ? (FP_WIDE_CAPABLE && FP_DATATYPE) : en_o.wide_int_en);
  endproperty

  a_dbg_entry: assert property (p_dbg_entry) else $error("debug mode not reached");
  a_dbg_priv: assert property (p_dbg_priv) else $error("debug lacks privilege");
  a_entry_kernel: assert property (p_entry_kernel) else $error("entry not kernel");
  a_kernel_priv: assert property (p_kernel_priv) else $error("kernel lacks access");
  a_user_op: assert property (p_user_op) else $error("user wide op denied");
  a_addr_err: assert property (p_addr_err) else $error("address error wrong");
  a_refill: assert property (p_refill) else $error("refill vector wrong");
  a_resv: assert property (p_resv) else $error("reserved instr missing");
  a_sys_cop: assert property (p_sys_cop) else $error("system unit access wrong");
  a_cop_absent: assert property (p_cop_absent) else $error("absent unit usable");
  a_fp_wide: assert property (p_fp_wide) else $error("float wide enable wrong");

  c_debug: cover property (en_o.mode == MODE_DEBUG);
  c_user: cover property (en_o.mode == MODE_USER);
  c_ext: cover property (fault_o.extended_refill);
  c_slverr: cover property (axil_o.rvalid && axil_o.rresp == RESP_SLVERR);
endmodule : privilege_mode_decode_sva

bind privilege_mode_decode privilege_mode_decode_sva #(
  .RELEASE_TWO(RELEASE_TWO), .FP_WIDE_CAPABLE(FP_WIDE_CAPABLE), .FP_DATATYPE(FP_DATATYPE),
  .COPROC_PRESENT(COPROC_PRESENT)
) u_sva (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .axil_o(axil_o), .exc_entry_i(exc_entry_i),
  .err_entry_i(err_entry_i), .debug_entry_i(debug_entry_i), .req_i(req_i),
  .en_o(en_o), .fault_o(fault_o)
);

// file: verification/core_side_model.sv
/*
  Decode and translation side: offers one random reference per cycle.
  Assumes the bench seeds the generator once.
*/
`timescale 1ns/1ps
module core_side_model
  import privilege_mode_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  output ref_req_t req_o // Reference to check
);
  logic [31:0] raw;
  ref_req_t nxt;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      req_o <= '0;
    else
    begin
      // no register numbers offered, so no odd wide float operands
      raw = $urandom;
      nxt = raw[$bits(ref_req_t)-1:0];
      // Only three spaces exist
      if (2'(nxt.space) == 2'h3)
        nxt.space = SPACE_USER;
      req_o <= nxt;
    end
  end
endmodule : core_side_model

// file: verification/testbench.sv
/*
  Self-checking bench: bus reads checked through an expectation queue.
  Assumes default design parameters (release two, wide float capable).
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import privilege_mode_pkg::*;
  logic clk_i;
  logic arst_n_i;
  axil_m2s_t m;
  axil_s2m_t s;
  logic [4:0] ev;
  ref_req_t req;
  enables_t en;
  fault_t flt;
  logic [33:0] q[$];
  logic [33:0] exp_v;
  logic [31:0] wv;
  int n_errors;
  int checks;

  privilege_mode_decode DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .axil_i(m), .axil_o(s),
    .exc_entry_i(ev[0]), .err_entry_i(ev[1]), .exception_return_i(ev[2]),
    .debug_entry_i(ev[3]), .debug_return_i(ev[4]), .req_i(req), .en_o(en), .fault_o(flt));
  core_side_model u_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_o(req));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Expected mode view from status and debug bits
  // ----------------------------------------------------------------
  function automatic logic [31:0] view(input logic [9:0] st, input logic db);
    logic [1:0] md;
    if (db)
      md = 2'h3;
    else if (st[0] || st[1] || st[3:2] == 2'h0)
      md = 2'h0;
    else if (st[3:2] == 2'h1)
      md = 2'h1;
    else
      md = 2'h2;
    view = {23'h0, st[6:4], (md == 2'h0 || md == 2'h3 || st[9]), st[8], 1'b1,
            (md != 2'h2 || st[7] || st[6]), md};
  endfunction : view

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, 32'h0});
    @(posedge clk_i);
    m.awvalid <= 1'b1;
    m.awaddr <= a;
    m.wvalid <= 1'b1;
    m.wdata <= d;
    m.wstrb <= 4'hf;
    m.bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s.awready && m.awvalid) m.awvalid <= 1'b0;
      if (s.wready && m.wvalid) m.wvalid <= 1'b0;
    end
    while (!s.bvalid);
    m.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, d});
    @(posedge clk_i);
    m.arvalid <= 1'b1;
    m.araddr <= a;
    m.rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s.arready && m.arvalid) m.arvalid <= 1'b0;
    end
    while (!s.rvalid);
    m.rready <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [4:0] p);
    @(posedge clk_i);
    ev <= p;
    @(posedge clk_i);
    ev <= 5'h0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  task automatic test_done;
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    if (s.bvalid && m.bready)
    begin
      exp_v = q.pop_front();
      `CHK({s.bresp, 32'h0}, exp_v)
    end
    if (s.rvalid && m.rready)
    begin
      exp_v = q.pop_front();
      `CHK({s.rresp, s.rdata}, exp_v)
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  initial
  begin
    arst_n_i = 1'b0;
    m = '0;
    ev = '0;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'h05a10a10));
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_STATUS_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_MODE_VIEW, view(10'h2, 1'b0), RESP_OKAY);
    wr(ADDR_FP_ID, 32'h0, RESP_OKAY);
    rd(ADDR_FP_ID, 32'h3, RESP_OKAY);
    wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h02, 32'h0, RESP_SLVERR);
    // Random control bits, mode view rechecked once both control registers are written
    repeat (40)
    begin
      wv = $urandom;
      wr(ADDR_STATUS_CTRL, wv, RESP_OKAY);
      wr(ADDR_DEBUG_CTRL, {31'h0, wv[31]}, RESP_OKAY);
      rd(ADDR_STATUS_CTRL, wv & 32'h3ff, RESP_OKAY);
      rd(ADDR_MODE_VIEW, view(wv[9:0], wv[31]), RESP_OKAY);
    end
    wr(ADDR_STATUS_CTRL, 32'h8, RESP_OKAY);
    wr(ADDR_DEBUG_CTRL, 32'h0, RESP_OKAY);
    pulse(5'h01);
    rd(ADDR_STATUS_CTRL, 32'h9, RESP_OKAY);
    pulse(5'h04);
    rd(ADDR_MODE_VIEW, view(10'h8, 1'b0), RESP_OKAY);
    pulse(5'h03);
    pulse(5'h04);
    rd(ADDR_MODE_VIEW, view(10'h9, 1'b0), RESP_OKAY);
    pulse(5'h05);
    rd(ADDR_STATUS_CTRL, 32'h9, RESP_OKAY);
    pulse(5'h04);
    pulse(5'h08);
    rd(ADDR_MODE_VIEW, view(10'h8, 1'b1), RESP_OKAY);
    pulse(5'h10);
    rd(ADDR_MODE_VIEW, view(10'h8, 1'b0), RESP_OKAY);
    test_done();
  end
endmodule : testbench
